//--- txim_top.sv
`timescale 1ns/1ps
`default_nettype none
module txim_top
    import txim_pkg::*;
#(
    parameter int PORTS = 4,
    parameter int DEPTH = TXIM_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Register port
    input wire txim_bus_t i_bus,
    output logic [7:0] o_rdata,
    // Per-port status sources and configuration
    input wire txim_port_in_t [PORTS-1:0] i_port,
    // Interrupt and pattern outputs
    output logic o_host_interrupt_n,
    output logic [PORTS-1:0][TXIM_PAT_W-1:0] o_repeat_pattern
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (PORTS < 1 || PORTS > 4) begin : g_chk_ports
        $error("txim_top: PORTS must be 1..4");
    end
    if (DEPTH < 1 || DEPTH > 127) begin : g_chk_depth
        $error("txim_top: DEPTH must be 1..127");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [PORTS-1:0][7:0] tx_int_mask_framer;
        logic [PORTS-1:0][7:0] tx_int_mask_hdlc;
        logic [PORTS-1:0][7:0] tx_int_mask_sync;
        logic [PORTS-1:0][7:0] tx_repeat_pattern_first;
        logic [PORTS-1:0][7:0] tx_repeat_pattern_second;
        logic [PORTS-1:0][TXIM_PAT_W-1:0] pattern;
        logic [7:0] rdata;
        logic irq_n;
    } txim_top_st_t;

    txim_top_st_t st;
    txim_top_st_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Port index from the upper address bits
    function automatic logic [1:0] txim_port_of(input logic [TXIM_ADDR_W-1:0] a);
        txim_port_of = a[TXIM_ADDR_W-1:TXIM_OFS_W];
    endfunction : txim_port_of

    // Offset within the port window
    function automatic logic [TXIM_OFS_W-1:0] txim_ofs_of(input logic [TXIM_ADDR_W-1:0] a);
        txim_ofs_of = a[TXIM_OFS_W-1:0];
    endfunction : txim_ofs_of

    // Mode dependent bits of the framer mask have no effect in the other mode
    function automatic logic [7:0] txim_eff_framer(input logic [7:0] m, input logic t1);
        logic [7:0] e;
        e = m;
        if (t1) begin
            e[TXIM_FR_ALIGN_BIT] = 1'b0;
        end else begin
            e[TXIM_FR_SLC_BIT] = 1'b0;
        end
        txim_eff_framer = e;
    endfunction : txim_eff_framer

    // Data-link empty enable counts only in T1
    function automatic logic [TXIM_HD_W-1:0] txim_eff_hdlc(input logic [7:0] m, input logic t1);
        logic [TXIM_HD_W-1:0] e;
        e = m[TXIM_HD_W-1:0];
        e[TXIM_HD_DLINK_BIT] = m[TXIM_HD_DLINK_BIT] & t1;
        txim_eff_hdlc = e;
    endfunction : txim_eff_hdlc

    // Pattern with bits beyond the selected length forced low
    function automatic logic [TXIM_PAT_W-1:0] txim_pattern(
        input logic [7:0] first,
        input logic [7:0] second,
        input logic [4:0] len
    );
        logic [4:0] l;
        logic [TXIM_PAT_W-1:0] keep;
        l = len;
        if (l < TXIM_PAT_LEN_MIN) begin
            l = TXIM_PAT_LEN_MIN;
        end
        if (l > TXIM_PAT_LEN_MAX) begin
            l = TXIM_PAT_LEN_MAX;
        end
        // Bit 15 is the first register's bit 7, the first bit sent
        keep = ~(16'hFFFF >> l);
        txim_pattern = {first, second} & keep;
    endfunction : txim_pattern

    ////////////////////////////////////////////////////////////////////////
    // Decode of the register port
    logic [1:0] acc_port;
    logic [TXIM_OFS_W-1:0] acc_ofs;
    logic acc_valid;

    // Port indices of PORTS and above answer as unmapped
    assign acc_port = txim_port_of(i_bus.addr);
    assign acc_ofs = txim_ofs_of(i_bus.addr);
    assign acc_valid = (32'(acc_port) < PORTS);

    ////////////////////////////////////////////////////////////////////////
    // Per-port latched status and FIFO flags
    logic [PORTS-1:0][TXIM_FR_W-1:0] stat_a;
    logic [PORTS-1:0][TXIM_HD_W-1:0] stat_b;
    logic [PORTS-1:0][TXIM_SY_W-1:0] stat_c;
    logic [PORTS-1:0] pend_a;
    logic [PORTS-1:0] pend_b;
    logic [PORTS-1:0] pend_c;
    txim_live_t [PORTS-1:0] live;
    logic [PORTS-1:0][6:0] space;

    for (genvar p = 0; p < PORTS; p++) begin : g_port
        logic sel;
        logic clr_a;
        logic clr_b;
        logic clr_c;
        logic below_rise;
        logic room_rise;
        logic [TXIM_HD_W-1:0] set_b;

        // Write one to clear, only for this port's window
        assign sel = i_bus.wr & acc_valid & (acc_port == 2'(p));
        assign clr_a = sel & (acc_ofs == TXIM_OFS_STAT_A);
        assign clr_b = sel & (acc_ofs == TXIM_OFS_STAT_B);
        assign clr_c = sel & (acc_ofs == TXIM_OFS_STAT_C);

        txim_fifo_flags #(
            .DEPTH(DEPTH)
        ) u_flags (
            .i_sys_clk(i_sys_clk),
            .i_reset(i_reset),
            .i_level(i_port[p].fifo_level),
            .i_low_mark(i_port[p].low_mark),
            .o_live(live[p]),
            .o_space(space[p]),
            .o_below_rise(below_rise),
            .o_room_rise(room_rise)
        );

        // Edge events of the live flags join the outside HDLC events
        assign set_b = {
            i_port[p].data_link_reg_empty,
            i_port[p].fifo_underrun_event,
            i_port[p].message_end_event,
            below_rise,
            room_rise
        };

        txim_sticky #(
            .W(TXIM_FR_W)
        ) u_stat_a (
            .i_sys_clk(i_sys_clk),
            .i_reset(i_reset),
            .i_set(i_port[p].framer_ev),
            .i_clear(clr_a ? i_bus.wdata : 8'h00),
            .i_mask(txim_eff_framer(st.tx_int_mask_framer[p], i_port[p].t1_mode)),
            .o_status(stat_a[p]),
            .o_pending(pend_a[p])
        );

        txim_sticky #(
            .W(TXIM_HD_W)
        ) u_stat_b (
            .i_sys_clk(i_sys_clk),
            .i_reset(i_reset),
            .i_set(set_b),
            .i_clear(clr_b ? i_bus.wdata[TXIM_HD_W-1:0] : 5'h00),
            .i_mask(txim_eff_hdlc(st.tx_int_mask_hdlc[p], i_port[p].t1_mode)),
            .o_status(stat_b[p]),
            .o_pending(pend_b[p])
        );

        txim_sticky #(
            .W(TXIM_SY_W)
        ) u_stat_c (
            .i_sys_clk(i_sys_clk),
            .i_reset(i_reset),
            .i_set(i_port[p].sync_loss_detect),
            .i_clear(clr_c & i_bus.wdata[0]),
            .i_mask(st.tx_int_mask_sync[p][0]),
            .o_status(stat_c[p]),
            .o_pending(pend_c[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: register writes, read data, pattern and interrupt
    always_comb begin
        next_st = st;

        // Register writes into the addressed port
        if (i_bus.wr && acc_valid) begin
            unique case (acc_ofs)
                TXIM_OFS_MASK_FRAMER: begin
                    next_st.tx_int_mask_framer[acc_port] = i_bus.wdata;
                end
                TXIM_OFS_MASK_HDLC: begin
                    next_st.tx_int_mask_hdlc[acc_port] = {3'h0, i_bus.wdata[4:0]};
                end
                TXIM_OFS_MASK_SYNC: begin
                    next_st.tx_int_mask_sync[acc_port] = {7'h00, i_bus.wdata[0]};
                end
                TXIM_OFS_PAT_FIRST: begin
                    next_st.tx_repeat_pattern_first[acc_port] = i_bus.wdata;
                end
                TXIM_OFS_PAT_SECOND: begin
                    next_st.tx_repeat_pattern_second[acc_port] = i_bus.wdata;
                end
                default: begin
                end
            endcase
        end

        // Read data stand only in the cycle after the strobe
        next_st.rdata = TXIM_RDATA_RST;
        if (i_bus.rd && acc_valid) begin
            unique case (acc_ofs)
                TXIM_OFS_STAT_A: begin
                    next_st.rdata = stat_a[acc_port];
                end
                TXIM_OFS_STAT_B: begin
                    next_st.rdata = {3'h0, stat_b[acc_port]};
                end
                TXIM_OFS_STAT_C: begin
                    next_st.rdata = {7'h00, stat_c[acc_port]};
                end
                TXIM_OFS_SUMMARY: begin
                    next_st.rdata = {5'h00, pend_c[acc_port], pend_b[acc_port],
                        pend_a[acc_port]};
                end
                TXIM_OFS_MASK_FRAMER: begin
                    next_st.rdata = st.tx_int_mask_framer[acc_port];
                end
                TXIM_OFS_MASK_HDLC: begin
                    next_st.rdata = st.tx_int_mask_hdlc[acc_port];
                end
                TXIM_OFS_MASK_SYNC: begin
                    next_st.rdata = st.tx_int_mask_sync[acc_port];
                end
                TXIM_OFS_PAT_FIRST: begin
                    next_st.rdata = st.tx_repeat_pattern_first[acc_port];
                end
                TXIM_OFS_PAT_SECOND: begin
                    next_st.rdata = st.tx_repeat_pattern_second[acc_port];
                end
                TXIM_OFS_LIVE_FLAGS: begin
                    next_st.rdata = {4'h0, live[acc_port]};
                end
                TXIM_OFS_SPACE: begin
                    next_st.rdata = {1'b0, space[acc_port]};
                end
                default: begin
                    next_st.rdata = TXIM_RDATA_RST;
                end
            endcase
        end

        // Pattern handed to the code generator, short lengths masked
        for (int p = 0; p < PORTS; p++) begin
            next_st.pattern[p] = txim_pattern(st.tx_repeat_pattern_first[p],
                st.tx_repeat_pattern_second[p], i_port[p].pattern_len);
        end

        // One registered stage keeps the pin glitch free
        next_st.irq_n = ~(|pend_a | |pend_b | |pend_c);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            st <= '0;
            st.tx_int_mask_framer <= {PORTS{TXIM_MASK_RST}};
            st.tx_int_mask_hdlc <= {PORTS{TXIM_MASK_RST}};
            st.tx_int_mask_sync <= {PORTS{TXIM_MASK_RST}};
            st.tx_repeat_pattern_first <= {PORTS{TXIM_PAT_RST}};
            st.tx_repeat_pattern_second <= {PORTS{TXIM_PAT_RST}};
            st.rdata <= TXIM_RDATA_RST;
            st.irq_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_rdata = st.rdata;
    assign o_host_interrupt_n = st.irq_n;
    assign o_repeat_pattern = st.pattern;

endmodule : txim_top
`default_nettype wire

//--- txim_pkg.sv
// Operation
// - Summary bits 2..0 flag pending status registers
// - Framer mask bits gate framer events, reset 0
// - Mask bit4 T1 only, bit3 E1 only
// - HDLC mask bits 3..0 gate FIFO events
// - HDLC mask bit4 enables data-link empty, T1
// - Sync mask uses bit 0 only
// - Each port copy at offset plus 200h steps
// - First pattern register, bit 7 sent first
// - Low pattern bits ignored by selected length
// - Second pattern register ignored for short lengths
// - Live FIFO flags unlatched, reset to zero
// - Bit 3 set when FIFO empty
// - Bit 2 set when FIFO full
// - Bit 1 set while below low watermark
// - Bit 0 set while a byte is free
// - Space count in bits 6..0
// - Summary flags clear when status is cleared
// - Interrupt output low while enabled status pending
// - Watermark and room events latch on rising edges
// - Framer status bits are latched event flags
package txim_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Address map, local offsets within one port window
    localparam int TXIM_ADDR_W = 11;
    localparam int TXIM_OFS_W = 9;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_STAT_A = 9'h190;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_STAT_B = 9'h191;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_STAT_C = 9'h192;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_SUMMARY = 9'h19F;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_MASK_FRAMER = 9'h1A0;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_MASK_HDLC = 9'h1A1;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_MASK_SYNC = 9'h1A2;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_PAT_FIRST = 9'h1AC;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_PAT_SECOND = 9'h1AD;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_LIVE_FLAGS = 9'h1B1;
    localparam logic [TXIM_OFS_W-1:0] TXIM_OFS_SPACE = 9'h1B3;
    localparam logic [TXIM_ADDR_W-1:0] TXIM_PORT_STRIDE = 11'h200;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and widths
    localparam int TXIM_FR_W = 8;
    localparam int TXIM_HD_W = 5;
    localparam int TXIM_SY_W = 1;
    localparam int TXIM_FR_ALIGN_BIT = 3;
    localparam int TXIM_FR_SLC_BIT = 4;
    localparam int TXIM_HD_DLINK_BIT = 4;
    localparam int TXIM_HD_BELOW_BIT = 1;
    localparam int TXIM_HD_ROOM_BIT = 0;
    localparam int TXIM_PAT_W = 16;
    localparam logic [4:0] TXIM_PAT_LEN_MIN = 5'h05;
    localparam logic [4:0] TXIM_PAT_LEN_MAX = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and FIFO size
    localparam logic [7:0] TXIM_MASK_RST = 8'h00;
    localparam logic [7:0] TXIM_PAT_RST = 8'h00;
    localparam logic [7:0] TXIM_RDATA_RST = 8'h00;
    localparam int TXIM_FIFO_DEPTH = 64;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [TXIM_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } txim_bus_t;

    typedef struct packed {
        logic [TXIM_FR_W-1:0] framer_ev;
        logic data_link_reg_empty;
        logic fifo_underrun_event;
        logic message_end_event;
        logic sync_loss_detect;
        logic [6:0] fifo_level;
        logic [6:0] low_mark;
        logic t1_mode;
        logic [4:0] pattern_len;
    } txim_port_in_t;

    typedef struct packed {
        logic fifo_is_empty;
        logic fifo_is_full;
        logic below_watermark_now;
        logic fifo_has_room;
    } txim_live_t;

endpackage : txim_pkg

//--- txim_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module txim_sticky
    import txim_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Events, clears and mask
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clear,
    input wire logic [W-1:0] i_mask,
    // Status
    output logic [W-1:0] o_status,
    output logic o_pending
);

    if (W < 1 || W > 8) begin : g_chk
        $error("txim_sticky: W must be 1..8");
    end

    typedef struct packed {
        logic [W-1:0] status;
    } txim_sticky_st_t;

    txim_sticky_st_t st;
    txim_sticky_st_t next_st;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        next_st = st;
        next_st.status = (st.status & ~i_clear) | i_set;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Pending drops as soon as software clears the bits
    assign o_status = st.status;
    assign o_pending = |(st.status & i_mask);

endmodule : txim_sticky
`default_nettype wire

//--- txim_fifo_flags.sv
`timescale 1ns/1ps
`default_nettype none
module txim_fifo_flags
    import txim_pkg::*;
#(
    parameter int DEPTH = TXIM_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // FIFO fill level and threshold
    input wire logic [6:0] i_level,
    input wire logic [6:0] i_low_mark,
    // Live flags, free space and edge pulses
    output txim_live_t o_live,
    output logic [6:0] o_space,
    output logic o_below_rise,
    output logic o_room_rise
);

    if (DEPTH < 1 || DEPTH > 127) begin : g_chk
        $error("txim_fifo_flags: DEPTH must be 1..127");
    end

    localparam logic [6:0] DEPTH_C = 7'(DEPTH);

    typedef struct packed {
        txim_live_t live;
        txim_live_t live_prev;
        logic [6:0] space;
        logic [1:0] armed;
    } txim_flags_st_t;

    txim_flags_st_t st;
    txim_flags_st_t next_st;

    // Flags follow the level each cycle, nothing is held
    always_comb begin
        logic [6:0] lvl;
        lvl = (i_level > DEPTH_C) ? DEPTH_C : i_level;
        next_st = st;
        next_st.live_prev = st.live;
        next_st.live.fifo_is_empty = (lvl == 7'h00);
        next_st.live.fifo_is_full = (lvl == DEPTH_C);
        next_st.live.below_watermark_now = (lvl < i_low_mark);
        next_st.live.fifo_has_room = (lvl != DEPTH_C);
        next_st.space = DEPTH_C - lvl;
        // Two edges pass before edges count, so the reset-to-idle step is no event
        next_st.armed = {st.armed[0], 1'b1};
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_live = st.live;
    assign o_space = st.space;
    // Rising edges of the watermark and room conditions feed the latched events
    assign o_below_rise = st.live.below_watermark_now & ~st.live_prev.below_watermark_now
        & st.armed[1];
    assign o_room_rise = st.live.fifo_has_room & ~st.live_prev.fifo_has_room
        & st.armed[1];

endmodule : txim_fifo_flags
`default_nettype wire

//--- txim_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module txim_top_properties
    import txim_pkg::*;
#(
    parameter int PORTS = 4,
    parameter int DEPTH = TXIM_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Register port
    input wire txim_bus_t i_bus,
    input wire logic [7:0] o_rdata,
    // Port sources and outputs
    input wire txim_port_in_t [PORTS-1:0] i_port,
    input wire logic o_host_interrupt_n,
    input wire logic [PORTS-1:0][TXIM_PAT_W-1:0] o_repeat_pattern
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    // Port 0 fill level, the only port these checks track
    logic [6:0] lvl;
    assign lvl = i_port[0].fifo_level;

    ////////////////////////////////////////////////////////////////////////
    // Read of port 0 while its FIFO inputs stay steady, so flags are settled
    sequence rd_p0(logic [8:0] ofs);
        i_bus.rd && i_bus.addr == {2'b00, ofs} && $stable(lvl) && $stable(i_port[0].low_mark);
    endsequence
    // Mask write followed by a read of the same place
    sequence wr_then_rd;
        i_bus.wr && i_bus.addr[8:0] == TXIM_OFS_MASK_FRAMER
        ##2 i_bus.rd && i_bus.addr == $past(i_bus.addr, 2);
    endsequence

    ////////////////////////////////////////////////////////////////////////
    mask_readback_a: assert property (wr_then_rd |=> o_rdata == $past(i_bus.wdata, 3))
        else $error("framer mask readback differs");
    hdlc_upper_a: assert property (i_bus.rd && i_bus.addr[8:0] == TXIM_OFS_MASK_HDLC
        |=> o_rdata[7:5] == 3'h0) else $error("hdlc mask upper bits set");
    sync_upper_a: assert property (i_bus.rd && i_bus.addr[8:0] == TXIM_OFS_MASK_SYNC
        |=> o_rdata[7:1] == 7'h00) else $error("sync mask upper bits set");
    summary_upper_a: assert property (i_bus.rd && i_bus.addr[8:0] == TXIM_OFS_SUMMARY
        |=> o_rdata[7:3] == 5'h00) else $error("summary upper bits set");
    irq_summary_a: assert property (i_bus.rd && i_bus.addr[8:0] == TXIM_OFS_SUMMARY
        |=> o_rdata[2:0] == 3'h0 || !o_host_interrupt_n) else $error("pending without irq");
    space_count_a: assert property (rd_p0(TXIM_OFS_SPACE) && lvl <= DEPTH
        |=> o_rdata == 8'(DEPTH - int'($past(lvl)))) else $error("space count wrong");
    live_full_a: assert property (rd_p0(TXIM_OFS_LIVE_FLAGS) && lvl <= DEPTH
        |=> o_rdata[7:2] == {4'h0, $past(lvl) == 0, $past(lvl) == DEPTH})
        else $error("empty or full flag wrong");
    live_room_a: assert property (rd_p0(TXIM_OFS_LIVE_FLAGS) && lvl <= DEPTH
        |=> o_rdata[1:0] == {$past(lvl) < $past(i_port[0].low_mark), $past(lvl) < DEPTH})
        else $error("watermark or room flag wrong");
    pattern_trim_a: assert property ($stable(i_port[0].pattern_len)
        && i_port[0].pattern_len inside {[5:16]}
        |-> (o_repeat_pattern[0] << i_port[0].pattern_len) == 16'h0000)
        else $error("pattern bits past length set");
endmodule : txim_top_properties

bind txim_top txim_top_properties #(.PORTS(PORTS), .DEPTH(DEPTH)) i_props (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_port(i_port), .o_host_interrupt_n(o_host_interrupt_n),
    .o_repeat_pattern(o_repeat_pattern));
`default_nettype wire

//--- txim_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module txim_top_test
    import txim_pkg::*;
();
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    txim_bus_t bus = '0;
    txim_port_in_t [3:0] pin = '0;
    logic [7:0] rdata;
    logic irq_n;
    logic [3:0][15:0] pat;
    int fail_count = 0;
    int compares = 0;

    txim_top #(.PORTS(4), .DEPTH(TXIM_FIFO_DEPTH)) i_dut (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
        .i_port(pin), .o_host_interrupt_n(irq_n), .o_repeat_pattern(pat));

    // 200 MHz clock
    initial forever #2.5 i_sys_clk = ~i_sys_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("counts: compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Strobes drop on the edge that samples them, so back-to-back calls never collide
    task automatic wr(input int p, input logic [8:0] o, input logic [7:0] d);
        @(posedge i_sys_clk);
        bus <= '{addr: {p[1:0], o}, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_sys_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rchk(input string n, input int p, input logic [8:0] o, input logic [7:0] e);
        @(posedge i_sys_clk);
        bus <= '{addr: {p[1:0], o}, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_sys_clk);
        bus.rd <= 1'b0;
        #1 chk(n, {8'h00, e}, {8'h00, rdata});
    endtask : rchk

    // One-cycle event pulse, then time for the interrupt to register
    task automatic ev(input int p, input logic [7:0] f, input logic [2:0] h, input logic s);
        @(posedge i_sys_clk);
        pin[p].framer_ev <= f;
        {pin[p].data_link_reg_empty, pin[p].fifo_underrun_event, pin[p].message_end_event} <= h;
        pin[p].sync_loss_detect <= s;
        @(posedge i_sys_clk);
        pin[p].framer_ev <= 8'h00;
        {pin[p].data_link_reg_empty, pin[p].fifo_underrun_event, pin[p].message_end_event} <= 3'h0;
        pin[p].sync_loss_detect <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
    endtask : ev

    // Hang guard, far beyond the roughly 600 cycles the tests need
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] fm[4], f, s;
        logic [15:0] ep;
        logic e, pb, pr;
        int lm, sb, lv[6];
        void'($urandom(45));
        repeat (10) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        for (int p = 0; p < 4; p++) pin[p].pattern_len <= 5'h05;
        // Reset values of the mask, pattern and HDLC status registers on every port
        for (int p = 0; p < 4; p++) begin
            rchk("framer mask rst", p, TXIM_OFS_MASK_FRAMER, 8'h00);
            rchk("hdlc mask rst", p, TXIM_OFS_MASK_HDLC, 8'h00);
            rchk("sync mask rst", p, TXIM_OFS_MASK_SYNC, 8'h00);
            rchk("pattern1 rst", p, TXIM_OFS_PAT_FIRST, 8'h00);
            rchk("pattern2 rst", p, TXIM_OFS_PAT_SECOND, 8'h00);
            rchk("hdlc status rst", p, TXIM_OFS_STAT_B, 8'h00);
        end
        $display("test reset values done");
        // Random masks per port; readback after all writes shows ports are separate
        for (int p = 0; p < 4; p++) begin
            fm[p] = 8'($urandom);
            wr(p, TXIM_OFS_MASK_FRAMER, fm[p]);
            rchk("framer mask", p, TXIM_OFS_MASK_FRAMER, fm[p]);
            wr(p, TXIM_OFS_MASK_HDLC, ~fm[p]);
            wr(p, TXIM_OFS_MASK_SYNC, ~fm[p]);
        end
        for (int p = 0; p < 4; p++) begin
            rchk("port framer mask", p, TXIM_OFS_MASK_FRAMER, fm[p]);
            rchk("port hdlc mask", p, TXIM_OFS_MASK_HDLC, ~fm[p] & 8'h1F);
            rchk("port sync mask", p, TXIM_OFS_MASK_SYNC, ~fm[p] & 8'h01);
            wr(p, TXIM_OFS_MASK_HDLC, 8'h00);
            wr(p, TXIM_OFS_MASK_SYNC, 8'h00);
            wr(p, TXIM_OFS_MASK_FRAMER, 8'h00);
        end
        $display("test mask registers done");
        // Each framer event alone, in both modes, then cleared
        for (int m = 0; m < 2; m++) begin
            for (int b = 0; b < 8; b++) begin
                @(posedge i_sys_clk);
                pin[1].t1_mode <= m[0];
                wr(1, TXIM_OFS_MASK_FRAMER, 8'h01 << b);
                ev(1, 8'h01 << b, 3'h0, 1'b0);
                e = !((b == 4 && m == 0) || (b == 3 && m == 1));
                rchk("framer summary", 1, TXIM_OFS_SUMMARY, {7'h00, e});
                chk("irq_n set", {15'h0, !e}, {15'h0, irq_n});
                rchk("framer status", 1, TXIM_OFS_STAT_A, 8'h01 << b);
                wr(1, TXIM_OFS_STAT_A, 8'hFF);
                rchk("summary clear", 1, TXIM_OFS_SUMMARY, 8'h00);
                chk("irq_n clear", 16'h0001, {15'h0, irq_n});
            end
        end
        $display("test framer events done");
        // HDLC and sync events: data link in T1 and E1, underrun, end, sync on and off
        wr(2, TXIM_OFS_MASK_HDLC, 8'h1C);
        for (int k = 0; k < 6; k++) begin
            @(posedge i_sys_clk);
            pin[2].t1_mode <= (k != 1);
            wr(2, TXIM_OFS_MASK_SYNC, {7'h00, k == 4});
            ev(2, 8'h00, {k < 2, k == 2, k == 3}, k >= 4);
            rchk("event summary", 2, TXIM_OFS_SUMMARY,
                k == 4 ? 8'h04 : (k == 1 || k == 5) ? 8'h00 : 8'h02);
            wr(2, TXIM_OFS_STAT_B, 8'hFF);
            wr(2, TXIM_OFS_STAT_C, 8'hFF);
            rchk("event clear", 2, TXIM_OFS_SUMMARY, 8'h00);
        end
        $display("test hdlc and sync events done");
        // FIFO levels around the boundaries and the watermark
        lm = 2 + $urandom % 62;
        lv = '{64, 63, lm, lm - 1, 1, 0};
        sb = 0;
        for (int i = 0; i < 6; i++) begin
            @(posedge i_sys_clk);
            pin[0].fifo_level <= 7'(lv[i]);
            pin[0].low_mark <= 7'(lm);
            repeat (3) @(posedge i_sys_clk);
            if (i == 0) wr(0, TXIM_OFS_STAT_B, 8'hFF);
            sb = (i == 0) ? 0 : sb | ((lv[i] < lm && !pb) ? 2 : 0) | ((lv[i] < 64 && !pr) ? 1 : 0);
            pb = lv[i] < lm;
            pr = lv[i] < 64;
            rchk("live flags", 0, TXIM_OFS_LIVE_FLAGS,
                {4'h0, lv[i] == 0, lv[i] == 64, pb, pr});
            rchk("space", 0, TXIM_OFS_SPACE, 8'(64 - lv[i]));
            rchk("fifo events", 0, TXIM_OFS_STAT_B, 8'(sb));
        end
        $display("test fifo flags done");
        // Every pattern length with random pattern contents
        f = 8'($urandom);
        s = 8'($urandom);
        wr(0, TXIM_OFS_PAT_FIRST, f);
        wr(0, TXIM_OFS_PAT_SECOND, s);
        for (int n = 5; n <= 16; n++) begin
            @(posedge i_sys_clk);
            pin[0].pattern_len <= 5'(n);
            repeat (3) @(posedge i_sys_clk);
            ep = ({f, s} >> (16 - n)) << (16 - n);
            #1 chk("pattern", ep, pat[0]);
        end
        $display("test pattern done");
        tally_and_finish();
    end
endmodule : txim_top_test
`default_nettype wire
